// file: logic/cws_controller.sv
// table controller end: issues four-cycle wide searches, collects flags
`timescale 1ns/1ps
module cws_controller
    import cws_pkg::*;
(
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst_n,
    cws_if.ctl                           link,
    input  wire logic                    i_req,
    input  wire logic [CWS_KEY_W-1:0]    i_key,
    input  wire logic [CWS_GMR_IDX_W-1:0] i_gmr_ab,
    input  wire logic [CWS_GMR_IDX_W-1:0] i_gmr_cd,
    input  wire logic [2:0]              i_addr_hi,
    input  wire logic [2:0]              i_ssr_idx,
    output logic                         o_busy,
    output logic                         o_res_valid,
    output logic                         o_res_found,
    output logic [CWS_ADDR_W-1:0]        o_res_addr
);
    cws_phase_e              phase_r;
    logic [CWS_CMD_W-1:0]    cmd_cd_r;
    logic [CWS_KEY_W-1:0]    key_r;
    logic [2:0]              ssr_r;
    logic                    cv_r;
    logic [CWS_CMD_W-1:0]    cmd_r;
    logic [CWS_DQ_W-1:0]     dq_r;
    logic                    rv_r;
    logic                    rf_r;
    logic [CWS_ADDR_W-1:0]   ra_r;

    // four command cycles, opcode every cycle, word order high to low
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_r <= CWS_PH_A;
            cmd_cd_r <= '0;
            key_r <= '0;
            ssr_r <= '0;
            cv_r <= 1'b0;
            cmd_r <= '0;
            dq_r <= '0;
        end
        else
        begin
            cv_r <= 1'b0;
            cmd_r <= '0;
            case (phase_r)
                CWS_PH_A:
                begin
                    if (i_req)
                    begin
                        cv_r <= 1'b1;
                        cmd_r <= {i_gmr_ab[3], 4'h0, i_gmr_ab[2:0], 1'b1, CWS_OP_SEARCH};
                        dq_r <= i_key[287:216];
                        key_r <= i_key;
                        ssr_r <= i_ssr_idx;
                        phase_r <= CWS_PH_B;
                        cmd_cd_r <= {i_gmr_cd[3], 1'b0, i_addr_hi, i_gmr_cd[2:0], 1'b0, CWS_OP_SEARCH};
                    end
                end
                CWS_PH_B:
                begin
                    cv_r <= 1'b1;
                    cmd_r <= {9'h000, CWS_OP_SEARCH};
                    dq_r <= key_r[215:144];
                    phase_r <= CWS_PH_C;
                end
                CWS_PH_C:
                begin
                    cv_r <= 1'b1;
                    cmd_r <= cmd_cd_r;
                    dq_r <= key_r[143:72];
                    phase_r <= CWS_PH_D;
                end
                CWS_PH_D:
                begin
                    cv_r <= 1'b1;
                    cmd_r <= {2'h0, ssr_r, 4'h0, CWS_OP_SEARCH};
                    dq_r <= key_r[71:0];
                    phase_r <= CWS_PH_A;
                end
                default: phase_r <= CWS_PH_A;
            endcase
        end
    end

    // flags and address sampled from the shared lines
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rv_r <= 1'b0;
            rf_r <= 1'b0;
            ra_r <= '0;
        end
        else
        begin
            rv_r <= link.search_valid_flag;
            rf_r <= link.search_found_flag;
            if (!link.ce_n)
                ra_r <= link.sram_address_out;
        end
    end

    assign link.command_valid = cv_r;
    assign link.cmd           = cmd_r;
    assign link.dq            = dq_r;
    assign o_busy             = (phase_r != CWS_PH_A);
    assign o_res_valid        = rv_r;
    assign o_res_found        = rf_r;
    assign o_res_addr         = ra_r;
endmodule

// file: logic/cws_device.sv
// search device end: command capture, compare, cascade arbitration, result timing
`timescale 1ns/1ps
module cws_device
    import cws_pkg::*;
(
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst_n,
    cws_if.dev                           link,
    input  wire logic [1:0]              i_table_size_field,
    input  wire logic [2:0]              i_hit_latency_field,
    input  wire logic                    i_default_sram_driver_bit,
    input  wire logic                    i_default_flag_driver_bit,
    input  wire logic                    i_first_in_block,
    input  wire logic                    i_first_block,
    input  wire logic [CWS_LHI_W-1:0]    i_local_hit_in,
    input  wire logic [CWS_BHI_W-1:0]    i_block_hit_in,
    input  wire logic                    i_entry_we,
    input  wire logic [CWS_IDX_W-1:0]    i_entry_idx,
    input  wire logic [CWS_DQ_W-1:0]     i_entry_data,
    input  wire logic [CWS_DQ_W-1:0]     i_entry_mask,
    input  wire logic                    i_gmr_we,
    input  wire logic [CWS_GMR_IDX_W-1:0] i_gmr_idx,
    input  wire logic [CWS_DQ_W-1:0]     i_gmr_data,
    input  wire logic [2:0]              i_result_sel,
    output logic                         o_local_hit_out,
    output logic                         o_block_hit_out,
    output logic [CWS_ADDR_W:0]          o_result_word
);
    // entry store; mask bit set means don't care
    logic [CWS_DQ_W-1:0]   ent_data [CWS_ENTRIES];
    logic [CWS_DQ_W-1:0]   ent_mask [CWS_ENTRIES];
    logic [CWS_DQ_W-1:0]   global_mask_register      [CWS_GMR_N];
    logic [CWS_ADDR_W:0]   result_reg [CWS_RES_N];

    cws_phase_e            phase_r;
    logic [CWS_KEY_W-1:0]  key_r;
    logic [CWS_GMR_IDX_W-1:0] gmr_ab_r;
    logic [CWS_GMR_IDX_W-1:0] gmr_cd_r;
    logic [2:0]            hi_bits_r;
    logic [2:0]            ssr_idx_r;
    logic [CWS_HIT_KNOWN-1:0] go_r;
    logic                  hit_r;
    logic [2:0]            ssr_pipe_r [CWS_PIPE_LEN];
    logic                  lwin_r;
    logic                  gwin_r;
    logic [CWS_ADDR_W-1:0] win_addr_r;
    logic [2:0]            win_ssr_r;
    logic [CWS_PIPE_LEN-1:0] srch_pipe_r;
    logic [CWS_PIPE_LEN-1:0] win_pipe_r;
    logic [CWS_ADDR_W-1:0] addr_pipe_r [CWS_PIPE_LEN];
    logic [CWS_ADDR_W-1:0] sram_address_out_r;
    logic                  sram_address_out_oe_n_r;
    logic                  ce_n_r;
    logic                  ssv_r;
    logic                  ssf_r;
    logic                  flag_oe_n_r;

    // command decode: opcode with valid; bit 2 starts a wide search
    wire is_search = link.command_valid && (link.cmd[1:0] == CWS_OP_SEARCH);
    wire start_a   = is_search && link.cmd[CWS_CMD_BIT_WIDE] && (phase_r == CWS_PH_A);
    wire [CWS_GMR_IDX_W-1:0] cmd_gmr = {link.cmd[CWS_CMD_BIT_GMRH], link.cmd[5:CWS_CMD_GMR_LO]};

    // global mask: pair from cycle A covers A,B, pair from cycle C covers C,D
    wire [CWS_KEY_W-1:0] gmr_full = {global_mask_register[{gmr_ab_r[3:1], 1'b0}], global_mask_register[{gmr_ab_r[3:1], 1'b1}],
                                     global_mask_register[{gmr_cd_r[3:1], 1'b0}], global_mask_register[{gmr_cd_r[3:1], 1'b1}]};

    // per-page match, only page starts are candidates
    logic [CWS_ENTRIES/4-1:0] page_hit;
    genvar gp;
    generate
        for (gp = 0; gp < CWS_ENTRIES/4; gp++)
        begin : g_page
            wire [CWS_KEY_W-1:0] pdat = {ent_data[gp*4], ent_data[gp*4+1], ent_data[gp*4+2], ent_data[gp*4+3]};
            wire [CWS_KEY_W-1:0] pmsk = {ent_mask[gp*4], ent_mask[gp*4+1], ent_mask[gp*4+2], ent_mask[gp*4+3]};
            assign page_hit[gp] = (((pdat ^ key_r) & ~pmsk & ~gmr_full) == '0);
        end
    endgenerate

    // lowest matching page wins
    logic [CWS_IDX_W-1:0] pri_idx;
    logic                 pri_hit;
    always_comb
    begin
        pri_idx = '0;
        pri_hit = 1'b0;
        for (int i = CWS_ENTRIES/4 - 1; i >= 0; i--)
        begin
            if (page_hit[i])
            begin
                pri_hit = 1'b1;
                pri_idx = {i[1:0], 2'b00};
            end
        end
    end

    // cascade: lose to any upstream hitter in block, then any earlier block
    wire up_local = |i_local_hit_in & ~i_first_in_block;
    wire up_block = |i_block_hit_in & ~i_first_block;

    // latency from C/D to address phase by size; extra 2 cycles are registers ahead
    wire [3:0] sram_address_out_lat = (i_table_size_field == CWS_TABLE_SIZE_FIELD_LARGE) ? 4'(CWS_LAT_BASE + 2) :
                          (i_table_size_field == CWS_TABLE_SIZE_FIELD_MID)   ? 4'(CWS_LAT_BASE + 1) :
                                                                   4'(CWS_LAT_BASE);
    wire [3:0] flag_lat = sram_address_out_lat + {1'b0, i_hit_latency_field};
    // winner known one cycle ahead of the slot; smaller tables skip arbitration stages
    wire       own_hit   = go_r[CWS_HIT_KNOWN-1] && hit_r;
    wire       sram_address_out_win  = (i_table_size_field == CWS_TABLE_SIZE_FIELD_LARGE) ? gwin_r :
                           (i_table_size_field == CWS_TABLE_SIZE_FIELD_MID)   ? lwin_r : own_hit;
    wire [3:0] pick      = sram_address_out_lat - 4'h3;  // slot tap of address and result index pipes
    wire       flag_slot = srch_pipe_r[flag_lat - 4'h1];
    wire       flag_win  = (i_hit_latency_field == CWS_HIT_LATENCY_FIELD_NONE) ? sram_address_out_win :
                           win_pipe_r[i_hit_latency_field - 3'h1];
    // the default driver cannot see others' win, so it backs off only on its own
    wire       win_any_sram_address_out = sram_address_out_win;
    wire       win_any_flag = flag_win;

    // table loading ports
    always_ff @(posedge i_mclk)
    begin
        if (i_entry_we)
        begin
            ent_data[i_entry_idx] <= i_entry_data;
            ent_mask[i_entry_idx] <= i_entry_mask;
        end
        if (i_gmr_we)
            global_mask_register[i_gmr_idx] <= i_gmr_data;
    end

    // command phase tracking and key capture; one search per four cycles
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_r   <= CWS_PH_A;
            key_r     <= '0;
            gmr_ab_r  <= '0;
            gmr_cd_r  <= '0;
            hi_bits_r <= '0;
            ssr_idx_r <= '0;
        end
        else
        begin
            case (phase_r)
                CWS_PH_A:
                begin
                    if (start_a)
                    begin
                        phase_r  <= CWS_PH_B;
                        key_r    <= {link.dq, key_r[CWS_KEY_W-CWS_DQ_W-1:0]};
                        gmr_ab_r <= cmd_gmr;
                    end
                end
                CWS_PH_B:
                begin
                    phase_r <= is_search ? CWS_PH_C : CWS_PH_A;
                    key_r[215:144] <= link.dq;
                end
                CWS_PH_C:
                begin
                    phase_r  <= (is_search && !link.cmd[CWS_CMD_BIT_WIDE]) ? CWS_PH_D : CWS_PH_A;
                    key_r[143:72] <= link.dq;
                    gmr_cd_r <= cmd_gmr;
                    hi_bits_r <= link.cmd[8:CWS_CMD_IDX_LO];
                end
                CWS_PH_D:
                begin
                    phase_r   <= CWS_PH_A;
                    key_r[71:0] <= link.dq;
                    ssr_idx_r <= link.cmd[8:CWS_CMD_IDX_LO];
                end
                default: phase_r <= CWS_PH_A;
            endcase
        end
    end

    // result pipeline: compare, local then block arbitration, output delay line
    wire search_d = (phase_r == CWS_PH_D) && is_search;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            go_r <= '0;
            hit_r <= 1'b0;
            lwin_r <= 1'b0;
            gwin_r <= 1'b0;
            win_addr_r <= '0;
            win_ssr_r <= '0;
            srch_pipe_r <= '0;
            win_pipe_r <= '0;
            for (int i = 0; i < CWS_PIPE_LEN; i++)
            begin
                addr_pipe_r[i] <= '0;
                ssr_pipe_r[i]  <= '0;
            end
        end
        else
        begin
            go_r <= {go_r[CWS_HIT_KNOWN-2:0], search_d};
            if (go_r[0])
            begin
                // address and result index caught before the next search overwrites them
                hit_r      <= pri_hit;
                win_addr_r <= {hi_bits_r, {(CWS_ADDR_W-3-CWS_IDX_W){1'b0}}, pri_idx};
                win_ssr_r  <= ssr_idx_r;
            end
            lwin_r <= own_hit && !up_local;
            gwin_r <= lwin_r && !up_block;
            srch_pipe_r <= {srch_pipe_r[CWS_PIPE_LEN-2:0], search_d};
            win_pipe_r  <= {win_pipe_r[CWS_PIPE_LEN-2:0], sram_address_out_win};
            addr_pipe_r[0] <= win_addr_r;
            ssr_pipe_r[0]  <= win_ssr_r;
            for (int i = 1; i < CWS_PIPE_LEN; i++)
            begin
                addr_pipe_r[i] <= addr_pipe_r[i-1];
                ssr_pipe_r[i]  <= ssr_pipe_r[i-1];
            end
        end
    end

    // pins: winner drives in its slot, default drivers otherwise or on global miss
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sram_address_out_r <= '0;
            sram_address_out_oe_n_r <= 1'b1;
            ce_n_r <= 1'b1;
            ssv_r <= 1'b0;
            ssf_r <= 1'b0;
            flag_oe_n_r <= 1'b1;
        end
        else
        begin
            sram_address_out_r <= sram_address_out_win ? addr_pipe_r[pick] : '0;
            ce_n_r <= ~sram_address_out_win;
            sram_address_out_oe_n_r <= ~(sram_address_out_win || (i_default_sram_driver_bit && !win_any_sram_address_out));
            ssv_r <= flag_slot;
            ssf_r <= flag_win;
            flag_oe_n_r <= ~(flag_win || (i_default_flag_driver_bit && !win_any_flag));
        end
    end

    // hit recorded in the selected result register by the slot winner: own, local or global by table size
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            for (int i = 0; i < CWS_RES_N; i++)
                result_reg[i] <= '0;
        else if (sram_address_out_win)
            result_reg[ssr_pipe_r[pick]] <= {1'b1, addr_pipe_r[pick]};
    end

    assign link.sram_address_out  = sram_address_out_r;
    assign link.sram_addr_oe_n    = sram_address_out_oe_n_r;
    assign link.ce_n              = ce_n_r;
    assign link.ale_n             = ce_n_r;
    assign link.we_n              = 1'b1;      // searches never write the sram
    assign link.search_valid_flag = ssv_r;
    assign link.search_found_flag = ssf_r;
    assign link.flag_oe_n         = flag_oe_n_r;
    assign o_local_hit_out        = own_hit || up_local;
    assign o_block_hit_out        = lwin_r || up_block;
    assign o_result_word          = result_reg[i_result_sel];
endmodule

// file: logic/cws_if.sv
// link between the table controller and one search device
`timescale 1ns/1ps
interface cws_if;
    import cws_pkg::*;
    logic                  command_valid;
    logic [CWS_CMD_W-1:0]  cmd;
    logic [CWS_DQ_W-1:0]   dq;
    logic [CWS_ADDR_W-1:0] sram_address_out;
    logic                  sram_addr_oe_n;
    logic                  ce_n;
    logic                  ale_n;
    logic                  we_n;
    logic                  search_valid_flag;
    logic                  search_found_flag;
    logic                  flag_oe_n;

    modport dev (input command_valid, cmd, dq,
                 output sram_address_out, sram_addr_oe_n, ce_n, ale_n, we_n,
                        search_valid_flag, search_found_flag, flag_oe_n);
    modport ctl (output command_valid, cmd, dq,
                 input sram_address_out, sram_addr_oe_n, ce_n, ale_n, we_n,
                       search_valid_flag, search_found_flag, flag_oe_n);
endinterface

// file: logic/cws_pkg.sv
// shared constants and types for the cascaded wide search pipeline
package cws_pkg;
    localparam int          CWS_DQ_W        = 72;
    localparam int          CWS_KEY_W       = 288;
    localparam int          CWS_CMD_W       = 11;
    localparam int          CWS_ADDR_W      = 24;
    localparam int          CWS_ENTRIES     = 16;   // entries per device model (four pages)
    localparam int          CWS_IDX_W       = 4;
    localparam int          CWS_GMR_N       = 16;
    localparam int          CWS_GMR_IDX_W   = 4;
    localparam int          CWS_RES_N       = 8;
    localparam int          CWS_LHI_W       = 7;
    localparam int          CWS_BHI_W       = 3;
    localparam int          CWS_DEV_PER_BLK = 8;
    localparam int          CWS_BLOCKS      = 4;
    localparam int          CWS_MAX_DEVS    = 31;
    localparam logic [1:0]  CWS_OP_SEARCH   = 2'h2;
    localparam logic [1:0]  CWS_TABLE_SIZE_FIELD_SMALL  = 2'h0;
    localparam logic [1:0]  CWS_TABLE_SIZE_FIELD_MID    = 2'h1;
    localparam logic [1:0]  CWS_TABLE_SIZE_FIELD_LARGE  = 2'h2;
    localparam logic [2:0]  CWS_HIT_LATENCY_FIELD_NONE   = 3'h0;
    localparam int          CWS_HIT_KNOWN   = 4;    // cycles to local result
    localparam int          CWS_LAT_BASE    = 4;    // latency for smallest table size
    localparam int          CWS_PIPE_LEN    = 16;   // delay line depth, covers 6 + 7
    localparam int          CWS_CMD_BIT_WIDE = 2;
    localparam int          CWS_CMD_BIT_GMRH = 10;
    localparam int          CWS_CMD_IDX_LO  = 6;
    localparam int          CWS_CMD_GMR_LO  = 3;

    typedef enum logic [3:0] {
        CWS_PH_A = 4'h1,
        CWS_PH_B = 4'h2,
        CWS_PH_C = 4'h4,
        CWS_PH_D = 4'h8
    } cws_phase_e;
endpackage

// file: testbench/cascaded_wide_search_pipeline_tb.sv
// self-checking bench: controller and device joined by the link
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module cascaded_wide_search_pipeline_tb
    import cws_pkg::*;
;
    localparam logic [CWS_KEY_W-1:0] KEY_A = {72'ha10000000000000001, 72'hb20000000000000002,
                                             72'hc30000000000000003, 72'hd40000000000000004};
    logic                     i_mclk = 1'b0, i_rst_n = 1'b0, req = 1'b0, entry_we = 1'b0, gmr_we = 1'b0;
    logic                     dsram = 1'b1, dflag = 1'b1, head_blk = 1'b1, head_dev = 1'b1;
    logic [1:0]               tsz = CWS_TABLE_SIZE_FIELD_LARGE;
    logic [2:0]               hit_latency_field = CWS_HIT_LATENCY_FIELD_NONE, addr_hi = 3'h0, ssr_idx = 3'h0, rsel = 3'h0;
    logic [CWS_LHI_W-1:0]     local_hit_in = 7'h00;
    logic [CWS_BHI_W-1:0]     block_hit_in = 3'h0;
    logic [CWS_IDX_W-1:0]     eidx = 4'h0;
    logic [CWS_GMR_IDX_W-1:0] gidx = 4'h0, gab = 4'h0, gcd = 4'h0;
    logic [CWS_DQ_W-1:0]      edata = 72'h0, emask = 72'h0, gdata = 72'h0;
    logic [CWS_KEY_W-1:0]     key = 288'h0;
    logic                     local_hit_out, block_hit_out, busy, rv, rf;
    logic [CWS_ADDR_W:0]      rword;
    logic [CWS_ADDR_W-1:0]    raddr;
    int                       failures = 0, samples_checked = 0, cyc = 0, ph = 0, t_d = 0, t_s = 0, t_v = 0;

    cws_if cws_if_i ();
    cws_device cws_device_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(cws_if_i.dev),
        .i_table_size_field(tsz), .i_hit_latency_field(hit_latency_field), .i_default_sram_driver_bit(dsram),
        .i_default_flag_driver_bit(dflag), .i_first_in_block(head_dev), .i_first_block(head_blk),
        .i_local_hit_in(local_hit_in), .i_block_hit_in(block_hit_in), .i_entry_we(entry_we), .i_entry_idx(eidx),
        .i_entry_data(edata), .i_entry_mask(emask), .i_gmr_we(gmr_we), .i_gmr_idx(gidx),
        .i_gmr_data(gdata), .i_result_sel(rsel), .o_local_hit_out(local_hit_out), .o_block_hit_out(block_hit_out),
        .o_result_word(rword));
    cws_controller cws_controller_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(cws_if_i.ctl),
        .i_req(req), .i_key(key), .i_gmr_ab(gab), .i_gmr_cd(gcd), .i_addr_hi(addr_hi),
        .i_ssr_idx(ssr_idx), .o_busy(busy), .o_res_valid(rv), .o_res_found(rf), .o_res_addr(raddr));
    cws_assertions cws_assertions_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .command_valid(cws_if_i.command_valid), .cmd(cws_if_i.cmd), .sram_addr_oe_n(cws_if_i.sram_addr_oe_n),
        .ce_n(cws_if_i.ce_n), .ale_n(cws_if_i.ale_n), .we_n(cws_if_i.we_n),
        .search_valid_flag(cws_if_i.search_valid_flag), .search_found_flag(cws_if_i.search_found_flag),
        .flag_oe_n(cws_if_i.flag_oe_n));

    always #12.5 i_mclk = ~i_mclk;

    // cycle stamps of cycle D, address slot and flags; hang guard
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        ph <= cws_if_i.command_valid ? (ph + 1) % 4 : 0;
        if (cws_if_i.command_valid === 1'b1 && ph == 3)
            t_d <= cyc;
        if (cws_if_i.ce_n === 1'b0)
            t_s <= cyc;
        if (cws_if_i.search_valid_flag === 1'b1)
            t_v <= cyc;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one-cycle entry write; the extra edge keeps strobes from colliding
    task automatic put(input logic [CWS_IDX_W-1:0] i, input logic [CWS_DQ_W-1:0] d);
        @(posedge i_mclk);
        entry_we <= 1'b1;
        eidx <= i;
        edata <= d;
        @(posedge i_mclk);
        entry_we <= 1'b0;
    endtask

    task automatic load_page(input int p, input logic [CWS_KEY_W-1:0] k);
        for (int w = 0; w < 4; w++)
            put(4'(4 * p + w), k[287 - 72 * w -: 72]);
    endtask

    // one search from request to collected flags, bounded waits
    task automatic search(input logic [CWS_KEY_W-1:0] k, input logic [2:0] hi, input logic [2:0] si,
                          output logic f, output logic [CWS_ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge i_mclk);
        while (busy !== 1'b0 && n < 50)
        begin
            @(posedge i_mclk);
            n++;
        end
        req <= 1'b1;
        key <= k;
        addr_hi <= hi;
        ssr_idx <= si;
        gab <= {1'b0, hi};
        gcd <= {1'b1, si};
        @(posedge i_mclk);
        req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (rv !== 1'b1 && n < 60);
        `CHK(rv, 1'b1)
        f = rf;
        a = raddr;
    endtask

    // hit, lowest page wins, stored result, miss and word order
    task automatic t_hits();
        logic f;
        logic [CWS_ADDR_W-1:0] a1, a2;
        load_page(1, KEY_A);
        load_page(2, KEY_A);
        search(KEY_A, 3'h5, 3'h3, f, a1);
        `CHK(f, 1'b1)
        `CHK(a1[1:0], 2'h0)
        `CHK(a1[23:21], 3'h5)
        @(posedge i_mclk);
        rsel <= 3'h3;
        repeat (2) @(posedge i_mclk);
        `CHK(rword, {1'b1, a1})
        put(4'h7, ~KEY_A[71:0]);
        search(KEY_A, 3'h5, 3'h6, f, a2);
        `CHK(f, 1'b1)
        `CHK(a2 == a1, 1'b0)
        search(~KEY_A, 3'h0, 3'h0, f, a2);
        `CHK(f, 1'b0)
        search({KEY_A[215:144], KEY_A[287:216], KEY_A[143:0]}, 3'h5, 3'h1, f, a2);
        `CHK(f, 1'b0)
        @(posedge i_mclk);
        gmr_we <= 1'b1;
        gidx <= 4'h2;
        gdata <= {CWS_DQ_W{1'b1}};
        @(posedge i_mclk);
        gmr_we <= 1'b0;
        search({~KEY_A[287:216], KEY_A[215:0]}, 3'h2, 3'h1, f, a2);
        `CHK(f, 1'b1)
        search({~KEY_A[287:216], KEY_A[215:0]}, 3'h0, 3'h1, f, a2);
        `CHK(f, 1'b0)
    endtask

    // slot latency per table size, then flag shift per hit latency
    task automatic t_latency();
        logic f;
        logic [CWS_ADDR_W-1:0] a;
        for (int s = 0; s < 3; s++)
        begin
            @(posedge i_mclk);
            tsz <= 2'(s);
            search(KEY_A, 3'h1, 3'h0, f, a);
            `CHK(t_s - t_d, CWS_LAT_BASE + s + 1)
        end
        for (int h = 0; h < 8; h++)
        begin
            @(posedge i_mclk);
            hit_latency_field <= 3'(h);
            search(KEY_A, 3'h1, 3'h0, f, a);
            `CHK(t_v - t_s, h)
        end
    endtask

    // losing to an upstream device, then to an upstream block
    task automatic t_cascade();
        logic f;
        logic [CWS_ADDR_W-1:0] a;
        @(posedge i_mclk);
        head_dev <= 1'b0;
        local_hit_in <= 7'h01;
        search(KEY_A, 3'h1, 3'h0, f, a);
        `CHK({f, local_hit_out}, 2'h1)
        head_dev <= 1'b1;
        head_blk <= 1'b0;
        block_hit_in <= 3'h1;
        search(KEY_A, 3'h1, 3'h0, f, a);
        `CHK({f, block_hit_out}, 2'h1)
        head_blk <= 1'b1;
        block_hit_in <= 3'h0;
        local_hit_in <= 7'h00;
    endtask

    // second search right behind the first, no idle cycle between
    task automatic t_b2b();
        int n, got;
        logic [1:0] fl;
        n = 0;
        got = 0;
        fl = 2'h0;
        @(posedge i_mclk);
        req <= 1'b1;
        key <= KEY_A;
        @(posedge i_mclk);
        req <= 1'b0;
        repeat (3) @(posedge i_mclk);
        `CHK(busy, 1'b1)
        req <= 1'b1;
        key <= ~KEY_A;
        @(posedge i_mclk);
        req <= 1'b0;
        n = 0;
        while (got < 2 && n < 60)
        begin
            @(posedge i_mclk);
            n++;
            if (rv === 1'b1)
            begin
                fl[got] = rf;
                got++;
            end
        end
        `CHK(got, 2)
        `CHK(fl, 2'h1)
    endtask

    // shared lines owned only by the default driver when idle
    task automatic t_driver();
        @(posedge i_mclk);
        dsram <= 1'b0;
        dflag <= 1'b0;
        repeat (3) @(posedge i_mclk);
        `CHK(cws_if_i.sram_addr_oe_n, 1'b1)
        `CHK(cws_if_i.flag_oe_n, 1'b1)
        dsram <= 1'b1;
        dflag <= 1'b1;
        repeat (3) @(posedge i_mclk);
        `CHK(cws_if_i.sram_addr_oe_n, 1'b0)
        `CHK(cws_if_i.flag_oe_n, 1'b0)
    endtask

    // reset, clear all global masks so every bit compares, then the scenarios
    initial
    begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        for (int g = 0; g < CWS_GMR_N; g++)
        begin
            @(posedge i_mclk);
            gmr_we <= 1'b1;
            gidx <= 4'(g);
            gdata <= '0;
        end
        @(posedge i_mclk);
        gmr_we <= 1'b0;
        t_hits();
        t_latency();
        t_cascade();
        t_b2b();
        t_driver();
        print_verdict();
    end
endmodule

// file: testbench/cws_assertions.sv
// link checks between the table controller and the search device
`timescale 1ns/1ps
module cws_assertions
    import cws_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 command_valid,
    input  wire logic [CWS_CMD_W-1:0] cmd,
    input  wire logic                 sram_addr_oe_n,
    input  wire logic                 ce_n,
    input  wire logic                 ale_n,
    input  wire logic                 we_n,
    input  wire logic                 search_valid_flag,
    input  wire logic                 search_found_flag,
    input  wire logic                 flag_oe_n
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // a search opens when valid rises from idle
    sequence s_open;
        $rose(command_valid);
    endsequence

    // address slot: one low cycle, quiet until the next search may land
    sequence s_slot;
        !ce_n && !ale_n ##1 ce_n [*3];
    endsequence

    // command side, four-cycle wide search framing
    a_open_wide: assert property (s_open |-> cmd[CWS_CMD_BIT_WIDE])
        else $error("wide mark missing in first cycle");
    a_valid_four: assert property (s_open |-> command_valid [*4])
        else $error("valid dropped inside a wide search");
    a_third_narrow: assert property (s_open |-> ##2 !cmd[CWS_CMD_BIT_WIDE])
        else $error("wide mark set in third cycle");
    a_search_code: assert property (command_valid |-> cmd[1:0] == CWS_OP_SEARCH)
        else $error("opcode is not search");

    // device side, result slot and flags
    a_slot_shape: assert property ($fell(ce_n) |-> s_slot)
        else $error("address slot shape wrong");
    a_no_write: assert property (!sram_addr_oe_n |-> we_n)
        else $error("write enable driven low");
    a_found_valid: assert property (search_found_flag |-> search_valid_flag)
        else $error("found without valid");
    a_flag_pulse: assert property (search_valid_flag |=> !search_valid_flag)
        else $error("valid flag longer than one cycle");
    a_flag_driven: assert property (search_valid_flag |-> !flag_oe_n)
        else $error("flag shown while not driven");
endmodule
